// ==== include/amp_fault_consts.svh ====
`ifndef AMP_FAULT_CONSTS_SVH
`define AMP_FAULT_CONSTS_SVH

// clock rate and timing figures
`define AFR_CLK_HZ 125000000
`define AFR_PULSE_US 10
`define AFR_PULSE_CYC ((`AFR_PULSE_US * (`AFR_CLK_HZ / 1000000)))
`define AFR_RESTART_US 20
`define AFR_RESTART_CYC ((`AFR_RESTART_US * (`AFR_CLK_HZ / 1000000)))
`define AFR_CNT_W 16
`define AFR_MODE_AUTO 3'h0
`define AFR_SYNC_W 3

`endif

// ==== include/amp_fault_pkg.sv ====
package amp_fault_pkg;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_FAULT = 2'b01,
		ST_RESTART = 2'b10,
		ST_REPORT = 2'b11
	} prot_state_e;
endpackage

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
`include "amp_fault_consts.svh"

// three-stage synchroniser; output changes once stages two and three agree
module pin_sync (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_async,
	output logic o_sync
);
	logic [`AFR_SYNC_W-1:0] stage_reg;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			stage_reg <= '0;
		end else begin
			stage_reg <= {stage_reg[`AFR_SYNC_W-2:0], i_async};
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sync <= 1'b0;
		end else if (stage_reg[1] == stage_reg[2]) begin
			o_sync <= stage_reg[2];
		end
	end
endmodule

// ==== src/amp_fault_status_reporting.sv ====
`timescale 1ns/1ps
`include "amp_fault_consts.svh"

// Overview of operation
// RULE1: drive both lines low on over-temperature error.
// RULE2: warning released, shutdown low means undervoltage or over-current.
// RULE3: both lines released means normal operation, nothing pending.
// RULE4: all three mode pins low selects auto-recovery after every error.
// RULE5: after restart, pulse shutdown low briefly, then resume normal.
// RULE6: warning outputs of all stages wire-OR onto one shared line.
// RULE7: shutdown outputs of all stages wire-OR onto one shared line.
// RULE8: fault lines are open drain: pull low or release.
// RULE9: controller synchronises and decodes both shared lines together.
module amp_fault_status_reporting #(
	parameter int PULSE_CYC = `AFR_PULSE_CYC,
	parameter int RESTART_CYC = `AFR_RESTART_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_temp_warn,
	input wire logic i_temp_err,
	input wire logic i_over_current,
	input wire logic i_under_voltage,
	input wire logic i_config_select_pins,
	input wire logic i_config_select_pins_b,
	input wire logic i_config_select_pins_c,
	input wire logic i_over_temp_warning_n,
	input wire logic i_shutdown_report_n,
	input wire logic i_clear_fault,
	output logic o_over_temp_warning_n,
	output logic o_over_temp_warning_n_oe,
	output logic o_shutdown_report_n,
	output logic o_shutdown_report_n_oe,
	output logic o_stage_enable,
	output logic o_auto_mode,
	output logic o_shared_warn,
	output logic o_shared_shutdown
);
	logic warn_s, terr_s, ocur_s, uvlo_s, m1_s, m2_s, m3_s, clr_s;
	logic otw_low_s, sd_low_s;
	logic [6:0] sync_out;
	logic [8:0] all_in;
	logic [8:0] all_sync;
	amp_fault_pkg::prot_state_e state_reg;
	logic [`AFR_CNT_W-1:0] cnt_reg;
	logic fault_any, auto_reg, ot_fault_reg, oc_fault_reg, uv_reg;
	logic drive_warn, drive_sd;

	// lines synced inverted, so the reset value matches a released line
	assign all_in = {i_temp_warn, i_temp_err, i_over_current,
		i_under_voltage, i_config_select_pins, i_config_select_pins_b,
		i_config_select_pins_c, i_clear_fault, ~i_over_temp_warning_n};

	genvar g;
	generate
		for (g = 0; g < 9; g++) begin : g_sync
			pin_sync u_sync (
				.i_clk_sys(i_clk_sys),
				.i_nrst(i_nrst),
				.i_async(all_in[g]),
				.o_sync(all_sync[g])
			);
		end
	endgenerate
	assign sync_out = all_sync[8:2];

	pin_sync u_sd_sync (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_async(~i_shutdown_report_n),
		.o_sync(sd_low_s)
	);

	assign {warn_s, terr_s, ocur_s, uvlo_s, m1_s, m2_s, m3_s} = sync_out;
	assign clr_s = all_sync[1];
	assign otw_low_s = all_sync[0];
	assign fault_any = terr_s | ocur_s | uvlo_s;

	// mode pins sampled while running; auto recovery only with all low
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			auto_reg <= 1'b0;
		end else if (state_reg == amp_fault_pkg::ST_RUN) begin
			auto_reg <= ({m1_s, m2_s, m3_s} == `AFR_MODE_AUTO); // RULE4
		end
	end

	// protection sequencer
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= amp_fault_pkg::ST_RUN;
			cnt_reg <= '0;
		end else begin
			unique case (state_reg)
			amp_fault_pkg::ST_RUN: begin
				cnt_reg <= '0;
				if (fault_any) begin
					state_reg <= amp_fault_pkg::ST_FAULT;
				end
			end
			amp_fault_pkg::ST_FAULT: begin
				// latched stages wait for an external clear
				if (!fault_any && (auto_reg || clr_s)) begin // RULE4
					state_reg <= amp_fault_pkg::ST_RESTART;
					cnt_reg <= '0;
				end
			end
			amp_fault_pkg::ST_RESTART: begin
				if (fault_any) begin
					state_reg <= amp_fault_pkg::ST_FAULT;
				end else if (cnt_reg == `AFR_CNT_W'(RESTART_CYC - 1)) begin
					state_reg <= amp_fault_pkg::ST_REPORT;
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
			amp_fault_pkg::ST_REPORT: begin
				if (fault_any) begin
					state_reg <= amp_fault_pkg::ST_FAULT;
				end else if (cnt_reg == `AFR_CNT_W'(PULSE_CYC - 1)) begin
					state_reg <= amp_fault_pkg::ST_RUN; // RULE5
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
			endcase
		end
	end

	// cause of the fault re-registered every cycle from the synced inputs, so it clears with them
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ot_fault_reg <= 1'b0;
			oc_fault_reg <= 1'b0;
			uv_reg <= 1'b0;
		end else begin
			ot_fault_reg <= terr_s;
			oc_fault_reg <= ocur_s;
			uv_reg <= uvlo_s;
		end
	end

	// decode: 00 temp error, 01 warning, 10 uvlo/current, 11 ok
	always_comb begin
		drive_warn = 1'b0;
		drive_sd = 1'b0;
		if (ot_fault_reg) begin
			drive_warn = 1'b1; // RULE1
			drive_sd = 1'b1;
		end else if (oc_fault_reg || uv_reg) begin
			drive_sd = 1'b1; // RULE2
		end else if (state_reg != amp_fault_pkg::ST_RUN) begin
			drive_sd = 1'b1; // RULE5
		end else if (warn_s) begin
			drive_warn = 1'b1; // RULE1
		end
	end

	// open drain: data held low, enable low while pulling (RULE8)
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_over_temp_warning_n <= 1'b0;
			o_over_temp_warning_n_oe <= 1'b1;
			o_shutdown_report_n <= 1'b0;
			o_shutdown_report_n_oe <= 1'b1;
		end else begin
			o_over_temp_warning_n <= 1'b0;
			o_shutdown_report_n <= 1'b0;
			o_over_temp_warning_n_oe <= !drive_warn; // RULE8 RULE3
			o_shutdown_report_n_oe <= !drive_sd; // RULE8 RULE3
		end
	end

	// shared-line view: low from any stage shows here (wire-OR of lows)
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_shared_warn <= 1'b0;
			o_shared_shutdown <= 1'b0;
		end else begin
			o_shared_warn <= otw_low_s; // RULE6
			o_shared_shutdown <= sd_low_s; // RULE7
		end
	end

	assign o_stage_enable = (state_reg == amp_fault_pkg::ST_RUN);
	assign o_auto_mode = auto_reg;

	property p_ot_code;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		ot_fault_reg |=> !o_over_temp_warning_n_oe && !o_shutdown_report_n_oe;
	endproperty
	a_ot_code: assert property (p_ot_code) else $error("ot code"); // RULE1

	property p_uv_code;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(uv_reg && !ot_fault_reg) |=>
			o_over_temp_warning_n_oe && !o_shutdown_report_n_oe;
	endproperty
	a_uv_code: assert property (p_uv_code) else $error("uv code"); // RULE2

	property p_normal;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(state_reg == amp_fault_pkg::ST_RUN && !ot_fault_reg &&
			!oc_fault_reg && !uv_reg && !warn_s) |=>
			o_over_temp_warning_n_oe && o_shutdown_report_n_oe;
	endproperty
	a_normal: assert property (p_normal) else $error("normal"); // RULE3

	property p_latch;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(state_reg == amp_fault_pkg::ST_FAULT && !auto_reg && !clr_s)
			|=> state_reg == amp_fault_pkg::ST_FAULT;
	endproperty
	a_latch: assert property (p_latch) else $error("latch"); // RULE4

	sequence s_report_start;
		$rose(state_reg == amp_fault_pkg::ST_REPORT);
	endsequence
	property p_pulse;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		s_report_start ##0 !fault_any[*2] |=> !o_shutdown_report_n_oe;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse"); // RULE5

	property p_od_data;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		!o_over_temp_warning_n && !o_shutdown_report_n;
	endproperty
	a_od_data: assert property (p_od_data) else $error("od data"); // RULE8

	property p_shared_warn;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		otw_low_s |=> o_shared_warn;
	endproperty
	a_shared_warn: assert property (p_shared_warn) else $error("sw"); // RULE6

	property p_shared_sd;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		sd_low_s |=> o_shared_shutdown;
	endproperty
	a_shared_sd: assert property (p_shared_sd) else $error("ssd"); // RULE7
endmodule

// ==== test/fault_monitor.sv ====
`timescale 1ns/1ps
// controller side: decodes both shared lines, may also act as a second stage
module fault_monitor (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_warn_line_n,
	input wire logic i_sd_line_n,
	input wire logic i_pull,
	output logic o_pull_oe,
	output logic [1:0] o_code
);
	logic [1:0] meta_reg;
	// second stage sinks both lines at once
	assign o_pull_oe = !i_pull;
	// two flops on the pair together so a short pulse decodes whole
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_reg <= 2'h3;
			o_code <= 2'h3;
		end else begin
			meta_reg <= {i_warn_line_n, i_sd_line_n};
			o_code <= meta_reg;
		end
	end
endmodule

// ==== test/amp_fault_status_reporting_tb.sv ====
`timescale 1ns/1ps
module amp_fault_status_reporting_tb;
	logic clk = 0, nrst = 0, warn = 0, terr = 0, oc = 0, uv = 0;
	logic m1 = 0, m2 = 0, m3 = 0, clr = 0, pull = 0;
	logic w_d, w_oe, s_d, s_oe, en, auto, sh_w, sh_s, p_oe;
	logic [1:0] code;
	int miscompares = 0, n_compared = 0, cyc = 0;
	wire w_line;
	wire s_line;
	// pull-up unless some stage sinks the line
	assign w_line = (w_oe || w_d) && p_oe;
	assign s_line = (s_oe || s_d) && p_oe;
	// restart hold and report pulse shortened for simulation
	localparam int PULSE = 4;
	localparam int RESTART = 8;
	// pin to line: three sync flops, agreement, state, output register
	localparam int LAT = 6;
	amp_fault_status_reporting #(.PULSE_CYC(PULSE), .RESTART_CYC(RESTART))
	amp_fault_status_reporting_inst (.i_clk_sys(clk), .i_nrst(nrst),
		.i_temp_warn(warn), .i_temp_err(terr), .i_over_current(oc),
		.i_under_voltage(uv), .i_config_select_pins(m1),
		.i_config_select_pins_b(m2), .i_config_select_pins_c(m3),
		.i_over_temp_warning_n(w_line), .i_shutdown_report_n(s_line),
		.i_clear_fault(clr), .o_over_temp_warning_n(w_d),
		.o_over_temp_warning_n_oe(w_oe), .o_shutdown_report_n(s_d),
		.o_shutdown_report_n_oe(s_oe), .o_stage_enable(en),
		.o_auto_mode(auto), .o_shared_warn(sh_w),
		.o_shared_shutdown(sh_s));
	fault_monitor fault_monitor_inst (.i_clk_sys(clk), .i_nrst(nrst),
		.i_warn_line_n(w_line), .i_sd_line_n(s_line), .i_pull(pull),
		.o_pull_oe(p_oe), .o_code(code));
	initial forever #4 clk = ~clk;
	task automatic chk(input logic [1:0] got, input logic [1:0] exp,
		input string m);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apply(input logic [3:0] f, input logic [1:0] exp);
		@(posedge clk);
		{warn, terr, oc, uv} <= f;
		step(8);
		chk({w_line, s_line}, exp, "line code");
		chk(code, exp, "decoded code");
		chk({w_d, s_d}, 2'h0, "drive level");
	endtask
	// lo, hi: cycles from fault gone to both lines released; 60 caps it
	task automatic wait_ok(input int lo, input int hi);
		int k = 0;
		logic seen = 1'b0;
		while ((w_line & s_line) !== 1'b1 && k < 60) begin
			step(1);
			k++;
			seen = seen | (code == 2'h2);
		end
		chk({k >= lo && k <= hi, en}, 2'h3, "recovery");
		chk({seen, en}, 2'h3, "report seen");
	endtask
	task automatic t_reset;
		chk({w_line, s_line}, 2'h3, "idle");
		chk({sh_w, sh_s}, 2'h0, "flags idle");
		chk({auto, en}, 2'h3, "auto mode");
	endtask
	task automatic t_warn;
		apply(4'h8, 2'h1);
		apply(4'h0, 2'h3);
	endtask
	task automatic t_errors;
		logic [3:0] f [5] = '{4'h4, 4'h2, 4'h1, 4'h6, 4'hc};
		logic [1:0] e [5] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0};
		for (int i = 0; i < 5; i++) begin
			apply(f[i], e[i]);
			@(posedge clk);
			{warn, terr, oc, uv} <= 4'h0;
			wait_ok(LAT + RESTART + PULSE, LAT + RESTART + PULSE);
		end
	endtask
	task automatic t_wired;
		@(posedge clk);
		pull <= 1'b1;
		step(7);
		chk({w_line, s_line}, 2'h0, "shared lines");
		chk({sh_w, sh_s}, 2'h3, "shared flags");
		chk({w_oe, s_oe}, 2'h3, "own release");
		chk(code, 2'h0, "monitor pulled");
		@(posedge clk);
		pull <= 1'b0;
		step(7);
		chk({sh_w, sh_s}, 2'h0, "flags clear");
	endtask
	task automatic t_manual;
		@(posedge clk);
		m2 <= 1'b1;
		step(8);
		chk({auto, en}, 2'h1, "manual mode");
		apply(4'h2, 2'h2);
		@(posedge clk);
		oc <= 1'b0;
		step(40);
		chk({w_line, s_line}, 2'h2, "held fault");
		@(posedge clk);
		clr <= 1'b1;
		wait_ok(LAT + RESTART + PULSE, LAT + RESTART + PULSE);
		@(posedge clk);
		clr <= 1'b0;
		m2 <= 1'b0;
		step(8);
		chk({auto, en}, 2'h3, "auto again");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			report_and_stop;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		step(8);
		t_reset;
		t_warn;
		t_errors;
		t_wired;
		t_manual;
		report_and_stop;
	end
endmodule
